// ---- core/dphs_defs.svh ----
`ifndef DPHS_DEFS_SVH
`define DPHS_DEFS_SVH

`define DPHS_ADDR_PHASE_LOW      7'h77
`define DPHS_ADDR_PHASE_HIGH     7'h78
`define DPHS_ADDR_ALARM_DELAY    7'h79
`define DPHS_ADDR_SOURCE_SEL     7'h4b
`define DPHS_SOURCE_SEL_BIT      4
`define DPHS_SOURCE_SEL_RESET    8'h00
`define DPHS_PHASE_LOW_RESET     8'h00
`define DPHS_PHASE_HIGH_RESET    8'h00
`define DPHS_ALARM_DELAY_RESET   6'h32
`define DPHS_ALARM_DELAY_WIDTH   6
`define DPHS_AVG_SHIFT           4

`endif

// ---- core/dphs_pkg.sv ----
package dphs_pkg;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [6:0]  addr;
        logic [7:0]  wdata;
    } dphs_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] sample;
    } dphs_phase_t;

endpackage : dphs_pkg

// ---- core/dphs_regs.sv ----
// Summary of operation
// - Address 0x77 reads the low byte of the phase-error word, read-only, zero after reset.
// - Address 0x78 reads the high byte, read-only, zero after reset, forming one 16-bit word.
// - The word comes from the first or second loop detector as bit 4 of address 0x4b picks.
// - The selected detector output is smoothed by an averager before it becomes readable.
// - Address 0x79 is a read/write alarm delay in two-second units, reset 0x32, bits 7:6 unused.
`timescale 1ns/10ps
`default_nettype none
`include "dphs_defs.svh"

module dphs_regs
    import dphs_pkg::*;
#(
    parameter int AVG_SHIFT = `DPHS_AVG_SHIFT
) (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire dphs_req_t   req,
    output logic      [7:0]  rdata,
    output logic             rvalid,
    input  wire dphs_phase_t first_digital_loop,
    input  wire dphs_phase_t second_digital_loop,
    output logic             loop_source_choice,
    output logic      [5:0]  alarm_delay
);

    logic        [7:0]  select_reg;
    logic signed [15:0] avg_phase;
    logic        [15:0] phase_word;
    logic        [5:0]  delay_reg;

    wire dphs_phase_t src          = select_reg[`DPHS_SOURCE_SEL_BIT] ?
                                     second_digital_loop : first_digital_loop;
    wire logic signed [16:0] diff  = 17'(signed'(src.sample)) - 17'(avg_phase);
    wire logic signed [16:0] step  = diff >>> AVG_SHIFT;
    wire logic signed [15:0] next_avg_phase = 16'(17'(avg_phase) + step);
    wire logic hit_select = req.addr == `DPHS_ADDR_SOURCE_SEL;
    wire logic hit_delay  = req.addr == `DPHS_ADDR_ALARM_DELAY;
    wire logic hit_low    = req.addr == `DPHS_ADDR_PHASE_LOW;
    wire logic hit_high   = req.addr == `DPHS_ADDR_PHASE_HIGH;
    wire logic hit_none   = !(hit_low || hit_high || hit_delay || hit_select);
    wire logic rd_low     = req.rd && hit_low;
    wire logic rd_high    = req.rd && hit_high;
    wire logic rd_delay   = req.rd && hit_delay && !req.wr;
    wire logic rd_select  = req.rd && hit_select && !req.wr;
    wire logic wr_delay   = req.wr && hit_delay;
    wire logic wr_select  = req.wr && hit_select;
    wire logic wr_phase   = req.wr && (hit_low || hit_high);
    wire logic [7:0] next_rdata = hit_low    ? phase_word[7:0] :
                                  hit_high   ? phase_word[15:8] :
                                  hit_delay  ? {2'b00, delay_reg} :
                                  hit_select ? select_reg : 8'h00;

    assign loop_source_choice = select_reg[`DPHS_SOURCE_SEL_BIT];
    assign alarm_delay        = delay_reg;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            avg_phase <= 16'sh0000;
        end else if (src.valid) begin
            avg_phase <= next_avg_phase;
        end
    end

    // Word holds on the cycle of a low-byte read, so a high-byte read in the next cycle matches
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            phase_word <= {`DPHS_PHASE_HIGH_RESET, `DPHS_PHASE_LOW_RESET};
        end else if (!rd_low) begin
            phase_word <= avg_phase;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            select_reg <= `DPHS_SOURCE_SEL_RESET;
            delay_reg  <= `DPHS_ALARM_DELAY_RESET;
        end else begin
            if (wr_select) select_reg <= req.wdata;
            if (wr_delay)  delay_reg  <= req.wdata[5:0];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdata  <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            if (req.rd) rdata <= next_rdata;
        end
    end

    // Checks on the register map and the averager
    a_delay_reset: assert property (
        @(posedge clk_sys)
        $rose(arst_n)
        |-> delay_reg == `DPHS_ALARM_DELAY_RESET)
        else $error("alarm delay reset value wrong");

    a_select_reset: assert property (
        @(posedge clk_sys)
        $rose(arst_n)
        |-> select_reg == `DPHS_SOURCE_SEL_RESET)
        else $error("source select reset value wrong");

    a_phase_reset: assert property (
        @(posedge clk_sys)
        $rose(arst_n)
        |-> phase_word[7:0] == `DPHS_PHASE_LOW_RESET && rdata == 8'h00 && !rvalid)
        else $error("low phase byte reset value wrong");

    a_high_reset: assert property (
        @(posedge clk_sys)
        $rose(arst_n)
        |-> phase_word[15:8] == `DPHS_PHASE_HIGH_RESET)
        else $error("high phase byte reset value wrong");

    a_delay_write: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        wr_delay
        |=> delay_reg == $past(req.wdata[5:0]))
        else $error("alarm delay write lost");

    a_delay_read: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        rd_delay
        |=> rdata[7:6] == 2'b00 && rdata[5:0] == delay_reg)
        else $error("alarm delay readback wrong");

    a_delay_port: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        wr_delay
        |=> alarm_delay == $past(req.wdata[5:0]))
        else $error("alarm delay output wrong");

    a_select_write: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        wr_select
        |=> loop_source_choice == $past(req.wdata[`DPHS_SOURCE_SEL_BIT]))
        else $error("source select write lost");

    a_select_read: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        rd_select
        |=> rdata == select_reg)
        else $error("source select readback wrong");

    a_source_pick: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        src.sample == (loop_source_choice ? second_digital_loop.sample
                                          : first_digital_loop.sample))
        else $error("phase source mux wrong");

    a_low_read: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        rd_low
        |=> rvalid && rdata == $past(phase_word[7:0]))
        else $error("low phase byte wrong");

    a_high_read: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        rd_high
        |=> rdata == $past(phase_word[15:8]))
        else $error("high phase byte wrong");

    a_pair_match: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        rd_low ##1 rd_high
        |=> rdata == $past(phase_word[15:8], 2))
        else $error("phase bytes from different words");

    a_phase_ro: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        wr_phase && !src.valid
        |=> $stable(avg_phase))
        else $error("phase word written by software");

    a_avg_hold: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        !src.valid
        |=> avg_phase == $past(avg_phase))
        else $error("averager moved without sample");

    a_avg_rise: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        src.valid && signed'(src.sample) > avg_phase
        |=> avg_phase >= $past(avg_phase) && avg_phase <= $past(signed'(src.sample)))
        else $error("averager overshot rising sample");

    a_avg_fall: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        src.valid && signed'(src.sample) < avg_phase
        |=> avg_phase <= $past(avg_phase) && avg_phase >= $past(signed'(src.sample)))
        else $error("averager overshot falling sample");

    a_rvalid_set: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        req.rd
        |=> rvalid)
        else $error("read not answered");

    a_rvalid_clear: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        !req.rd
        |=> !rvalid)
        else $error("answer without read");

    a_rdata_hold: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        !req.rd
        |=> $stable(rdata))
        else $error("read data moved without read");

    a_unmapped_zero: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        req.rd && hit_none
        |=> rdata == 8'h00)
        else $error("unmapped read not zero");

endmodule // dphs_regs
`default_nettype wire

// ---- bench/test_dphs_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_dphs_regs import dphs_pkg::*;;
    logic        clk_sys = 0;
    logic        arst_n = 0;
    dphs_req_t   req = '0;
    dphs_phase_t lp1 = '0, lp2 = '0;
    logic [7:0]  rdata, exp_q[$];
    logic        rvalid, sel;
    logic [5:0]  dly;
    int          n_mismatch = 0, checks = 0, seed = 1, avg = 0, s, i;
    always #2 clk_sys = ~clk_sys;
    dphs_regs dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .req(req), .rdata(rdata),
        .rvalid(rvalid), .first_digital_loop(lp1), .second_digital_loop(lp2),
        .loop_source_choice(sel), .alarm_delay(dly));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic w, r, input logic [6:0] a, input logic [7:0] d, e);
        @(negedge clk_sys);
        req = '{w, r, a, d};
        if (r) exp_q.push_back(e);
    endtask
    task automatic stream(input logic pick);
        avg = 0;
        for (i = 0; i < 24; i++) begin
            @(negedge clk_sys);
            s = $random(seed) % 2048;
            lp1 = '{1'b1, pick ? 16'($random(seed)) : s[15:0]};
            lp2 = '{1'b1, pick ? s[15:0] : 16'($random(seed))};
            avg = avg + ((s - avg) >>> 4);
        end
        @(negedge clk_sys);
        lp1.valid = 1'b0;
        lp2.valid = 1'b0;
        repeat (3) @(negedge clk_sys);
        acc(0, 1, 7'h77, 8'h00, avg[7:0]);
        acc(0, 1, 7'h78, 8'h00, avg[15:8]);
        acc(0, 0, 7'h00, 8'h00, 8'h00);
    endtask
    task automatic drain;
        for (i = 0; i < 20 && exp_q.size() != 0; i++) @(negedge clk_sys);
        if (exp_q.size() != 0) n_mismatch++;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(negedge clk_sys) if (rvalid === 1'b1) begin
        if (exp_q.size() == 0) n_mismatch++;
        else chk(rdata, exp_q.pop_front());
    end
    initial #100000 begin
        n_mismatch++;
        report_and_stop;
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys) arst_n = 1;
        chk({2'h0, dly}, 8'h32);
        chk({7'h0, sel}, 8'h00);
        acc(0, 1, 7'h77, 8'h00, 8'h00);
        acc(0, 1, 7'h78, 8'h00, 8'h00);
        acc(0, 1, 7'h79, 8'h00, 8'h32);
        acc(1, 0, 7'h77, 8'hff, 8'h00);
        acc(1, 0, 7'h78, 8'hff, 8'h00);
        acc(1, 0, 7'h79, 8'hff, 8'h00);
        acc(1, 0, 7'h4b, 8'h10, 8'h00);
        acc(0, 1, 7'h77, 8'h00, 8'h00);
        acc(0, 1, 7'h78, 8'h00, 8'h00);
        acc(0, 1, 7'h79, 8'h00, 8'h3f);
        acc(0, 1, 7'h4b, 8'h00, 8'h10);
        acc(0, 1, 7'h10, 8'h00, 8'h00);
        acc(0, 0, 7'h00, 8'h00, 8'h00);
        chk({2'h0, dly}, 8'h3f);
        chk({7'h0, sel}, 8'h01);
        stream(1'b1);
        drain;
        @(negedge clk_sys) arst_n = 0;
        repeat (3) @(negedge clk_sys);
        arst_n = 1;
        chk({2'h0, dly}, 8'h32);
        chk({7'h0, sel}, 8'h00);
        acc(0, 1, 7'h78, 8'h00, 8'h00);
        acc(0, 1, 7'h79, 8'h00, 8'h32);
        acc(0, 0, 7'h00, 8'h00, 8'h00);
        stream(1'b0);
        drain;
        report_and_stop;
    end
endmodule // test_dphs_regs
`default_nettype wire
